//--- hw/rss_defines.vh
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
// ==========================================================
// Register offsets (byte addresses on the plain port)
`define RSS_ADDR_W 4
`define RSS_OFS_CAUSE 4'h0
`define RSS_OFS_CONFIG 4'h4
`define RSS_OFS_COUNT 4'h8
`define RSS_OFS_STATE 4'hc
// ==========================================================
// Cause register bit positions
`define RSS_CB_LOW_V 1
`define RSS_CB_BAD_FETCH 3
`define RSS_CB_BAD_OP 4
`define RSS_CB_WDOG 5
`define RSS_CB_PIN 6
`define RSS_CB_POR 7
// ==========================================================
// Config register bit positions and reset value
`define RSS_FB_WDOG_DIS 0
`define RSS_FB_STOP_EN 1
`define RSS_FB_SHORT_WAKE 2
`define RSS_FB_LV_PWR_OFF 3
`define RSS_FB_LV_RST_OFF 4
`define RSS_FB_MONITOR 5
`define RSS_CONFIG_RST 8'h00
// ==========================================================
// Timing in oscillator cycles (clk_sys_i period is one cycle)
`define RSS_PIN_MIN_CYC 12'd67
`define RSS_PIN_DRIVE_CYC 12'd32
`define RSS_TAIL_CYC 12'd32
`define RSS_LONG_CYC 12'd4095
`define RSS_RELEASE_CYC 12'd64
`define RSS_SHORT_WAKE_CYC 12'd32
// ==========================================================
// Reset vectors
`define RSS_VEC_NORMAL 16'hfffe
`define RSS_VEC_MONITOR 16'hfefe
`define RSS_IRQ_N 8
`endif

//--- hw/rss_reset_seq.v
`timescale 1ns/100ps
`include "rss_defines.vh"
// How it works
// - Any reset asserts internal reset, selects vector
// - Internal reset clears counter; pin reset not
// - Each source sets its own cause flag
// - Low reset pin halts all processing
// - Pin flag needs 67 cycles, no power/low-voltage
// - Internal: pin low 32, then 32 more
// - Power/low-voltage: pin low 4096 first
// - Power-on: clocks off 4096, release 64 later
// - Power-on enables clock generator output
// - Power-on sets its flag, clears others
// - Watchdog overflow resets unless disabled
// - Watchdog reset independent of bus cycles
// - Undefined opcode sets flag and resets
// - Stop with stop disabled is bad opcode
// - Unmapped opcode fetch resets; data does not
// - Low voltage resets unless either bit set
// - 12-bit prescaler, overflow clocks watchdog
// - Stop clears counter; wake delay 32 or 4096
// - Counter free-runs after reset states
// - Interrupt entry stacks; return restores
// - Requests latched, arbitrated into vector code
// - Latched interrupt not displaced until serviced
// - Reset always beats interrupts
// - Reading cause register clears all flags
module rss_reset_seq (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // Reset sources
  input wire power_on_pulse_i,
  input wire low_voltage_i,
  input wire wdog_overflow_i,
  input wire bad_opcode_i,
  input wire stop_exec_i,
  input wire opcode_fetch_i,
  input wire unmapped_addr_i,
  input wire wake_event_i,
  // Reset pin, open drain
  input wire reset_pin_n_i,
  output reg reset_pin_oe_o,
  output reg reset_pin_o,
  // CPU side
  output reg internal_reset_signal_o,
  output reg cpu_clk_en_o,
  output reg clock_generator_output_o,
  output reg [15:0] reset_vector_o,
  output reg wdog_tick_o,
  input wire [`RSS_IRQ_N-1:0] irq_req_i,
  input wire irq_mask_i,
  input wire irq_entry_i,
  input wire irq_return_i,
  output reg irq_pending_o,
  output reg [2:0] irq_vector_o,
  output reg stack_push_o,
  output reg stack_pop_o,
  // Register port
  input wire [`RSS_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o
);
  // ==========================================================
  // Sequencer states
  localparam ST_RUN = 3'd0;
  localparam ST_LONG = 3'd1;
  localparam ST_DRIVE = 3'd2;
  localparam ST_TAIL = 3'd3;
  localparam ST_EXT = 3'd4;
  localparam ST_STOP = 3'd5;
  localparam ST_WAKE = 3'd6;
  reg [2:0] state_q; // Sequencer state
  reg [11:0] pre_q; // Prescale counter
  reg [11:0] seq_q; // Phase timer
  reg [6:0] pin_low_q; // Pin low time, saturating
  reg [7:0] cause_q; // Reset cause register
  reg [7:0] config_q; // Configuration bits
  reg [1:0] pin_sync_q; // Pin synchroniser
  reg [1:0] lv_sync_q; // Low-voltage synchroniser
  reg pin_low_q1; // Second stage of pin sync, delayed
  reg irq_latched_q; // An interrupt is latched
  reg [2:0] irq_sel_q; // Latched vector code
  reg ext_cause_q; // Source of running sequence was power or lv
  wire pin_low = ~pin_sync_q[1];
  wire lv_low = lv_sync_q[1];
  wire lv_arm = lv_low & ~config_q[`RSS_FB_LV_PWR_OFF] & ~config_q[`RSS_FB_LV_RST_OFF];
  wire wd_hit = wdog_overflow_i & ~config_q[`RSS_FB_WDOG_DIS];
  wire stop_bad = stop_exec_i & ~config_q[`RSS_FB_STOP_EN];
  wire op_hit = bad_opcode_i | stop_bad;
  wire ad_hit = unmapped_addr_i & opcode_fetch_i;
  wire int_hit = wd_hit | op_hit | ad_hit;
  wire in_reset = (state_q != ST_RUN) && (state_q != ST_STOP) && (state_q != ST_WAKE);
  wire cause_rd = reg_rd_i && (reg_addr_i == `RSS_OFS_CAUSE);
  reg [2:0] pri_code; // Highest-priority request
  integer k;
  // ==========================================================
  // Priority encode: low index wins
  always @* begin
    pri_code = 3'd0;
    for (k = `RSS_IRQ_N-1; k >= 0; k = k - 1) begin
      if (irq_req_i[k]) begin
        pri_code = k[2:0];
      end
    end
  end
  // ==========================================================
  // Input synchronisers; the first stage feeds only the second
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync_q <= 2'b11;
      lv_sync_q <= 2'b00;
    end else begin
      pin_sync_q <= {pin_sync_q[0], reset_pin_n_i};
      lv_sync_q <= {lv_sync_q[0], low_voltage_i};
    end
  end
  // ==========================================================
  // Sequencer, prescaler and cause flags. The prescaler counts on the
  // system clock edge; the oscillator falling edge is modelled by this
  // single domain to avoid a second clock tree.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_LONG;
      pre_q <= 12'h000;
      seq_q <= 12'h000;
      pin_low_q <= 7'h00;
      pin_low_q1 <= 1'b0;
      cause_q <= 8'h00;
      ext_cause_q <= 1'b1;
      wdog_tick_o <= 1'b0;
    end else begin
      wdog_tick_o <= (pre_q == 12'hfff);
      pin_low_q1 <= pin_low;
      // Cause read clears; a new cause in the same cycle still sets
      if (cause_rd) begin
        cause_q <= 8'h00;
      end
      if (power_on_pulse_i) begin
        cause_q <= 8'h80;
        state_q <= ST_LONG;
        seq_q <= 12'h000;
        pre_q <= 12'h000;
        ext_cause_q <= 1'b1;
      end else if (lv_arm) begin
        cause_q[`RSS_CB_LOW_V] <= 1'b1;
        state_q <= ST_LONG;
        seq_q <= 12'h000;
        pre_q <= 12'h000;
        ext_cause_q <= 1'b1;
      end else if (int_hit && !in_reset) begin
        // Reset taken immediately, not on a bus boundary
        if (wd_hit) cause_q[`RSS_CB_WDOG] <= 1'b1;
        if (op_hit) cause_q[`RSS_CB_BAD_OP] <= 1'b1;
        if (ad_hit) cause_q[`RSS_CB_BAD_FETCH] <= 1'b1;
        state_q <= ST_DRIVE;
        seq_q <= 12'h000;
        pre_q <= 12'h000;
        ext_cause_q <= 1'b0;
      end else if (pin_low && !in_reset) begin
        state_q <= ST_EXT;
        pin_low_q <= 7'h00;
        pre_q <= pre_q + 12'h001; // External reset leaves counter running
      end else begin
        case (state_q)
          ST_RUN: begin
            pre_q <= pre_q + 12'h001;
            if (stop_exec_i && !stop_bad) begin
              pre_q <= 12'h000;
              state_q <= ST_STOP;
            end
          end
          ST_LONG: begin
            pre_q <= pre_q + 12'h001;
            if (pre_q == `RSS_LONG_CYC) begin
              state_q <= ST_TAIL;
              seq_q <= 12'h000;
            end
          end
          ST_DRIVE: begin
            seq_q <= seq_q + 12'h001;
            if (seq_q == `RSS_PIN_DRIVE_CYC - 12'd1) begin
              state_q <= ST_TAIL;
              seq_q <= 12'h000;
            end
          end
          ST_TAIL: begin
            seq_q <= seq_q + 12'h001;
            pre_q <= pre_q + 12'h001;
            // Power and low-voltage paths wait 64, others 32
            if (seq_q == (ext_cause_q ? `RSS_RELEASE_CYC : `RSS_TAIL_CYC) - 12'd1) begin
              state_q <= ST_RUN;
            end
          end
          ST_EXT: begin
            pre_q <= pre_q + 12'h001;
            if (pin_low_q != 7'h7f) pin_low_q <= pin_low_q + 7'h01;
            if (!pin_low_q1) begin
              // Pin flag only on a long enough pulse
              if (pin_low_q >= `RSS_PIN_MIN_CYC) cause_q[`RSS_CB_PIN] <= 1'b1;
              state_q <= ST_TAIL;
              seq_q <= 12'h000;
              ext_cause_q <= 1'b0;
            end
          end
          ST_STOP: begin
            pre_q <= 12'h000; // Held clear through stop
            if (wake_event_i) state_q <= ST_WAKE;
          end
          ST_WAKE: begin
            pre_q <= pre_q + 12'h001;
            // Short or long wake delay
            if (pre_q == (config_q[`RSS_FB_SHORT_WAKE] ? `RSS_SHORT_WAKE_CYC - 12'd1 : `RSS_LONG_CYC)) begin
              state_q <= ST_RUN;
            end
          end
          default: begin
            state_q <= ST_LONG;
          end
        endcase
      end
    end
  end
  // ==========================================================
  // Output drive, all registered
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      internal_reset_signal_o <= 1'b1;
      reset_pin_oe_o <= 1'b1;
      reset_pin_o <= 1'b0;
      cpu_clk_en_o <= 1'b0;
      clock_generator_output_o <= 1'b1;
      reset_vector_o <= `RSS_VEC_NORMAL;
    end else begin
      internal_reset_signal_o <= in_reset;
      // Drive pin low in long and drive phases
      reset_pin_oe_o <= (state_q == ST_LONG) || (state_q == ST_DRIVE);
      reset_pin_o <= 1'b0;
      cpu_clk_en_o <= (state_q == ST_RUN);
      clock_generator_output_o <= (state_q != ST_STOP);
      reset_vector_o <= config_q[`RSS_FB_MONITOR] ? `RSS_VEC_MONITOR : `RSS_VEC_NORMAL;
    end
  end
  // ==========================================================
  // Interrupt latch and stacking strobes
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_latched_q <= 1'b0;
      irq_sel_q <= 3'd0;
      irq_pending_o <= 1'b0;
      irq_vector_o <= 3'd0;
      stack_push_o <= 1'b0;
      stack_pop_o <= 1'b0;
    end else begin
      stack_push_o <= 1'b0;
      stack_pop_o <= 1'b0;
      if (in_reset) begin
        irq_latched_q <= 1'b0;
      end else if (irq_latched_q) begin
        // Held against any newcomer
        if (irq_entry_i) begin
          stack_push_o <= 1'b1;
          irq_latched_q <= 1'b0;
        end else if (irq_mask_i == 1'b0 && irq_req_i == {`RSS_IRQ_N{1'b0}}) begin
          irq_latched_q <= 1'b0;
        end
      end else if (!irq_mask_i && (irq_req_i != {`RSS_IRQ_N{1'b0}})) begin
        irq_latched_q <= 1'b1;
        irq_sel_q <= pri_code;
      end
      if (irq_return_i && !in_reset) stack_pop_o <= 1'b1;
      irq_pending_o <= irq_latched_q & ~in_reset;
      irq_vector_o <= irq_sel_q;
    end
  end
  // ==========================================================
  // Register port: config write, reads one cycle later
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_q <= `RSS_CONFIG_RST;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == `RSS_OFS_CONFIG) config_q <= reg_wdata_i;
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `RSS_OFS_CAUSE: reg_rdata_o <= cause_q;
          `RSS_OFS_CONFIG: reg_rdata_o <= config_q;
          `RSS_OFS_COUNT: reg_rdata_o <= pre_q[11:4];
          `RSS_OFS_STATE: reg_rdata_o <= {5'h00, state_q};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // rss_reset_seq

//--- sim/rss_reset_seq_props.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker for the reset sequencer
module rss_reset_seq_chk (
  // Clock, reset and observed ports
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire bad_opcode_i,
  input wire reset_pin_n_i,
  input wire reg_rd_i,
  input wire cpu_clk_en_o,
  input wire reset_pin_oe_o,
  input wire reset_pin_o,
  input wire internal_reset_signal_o,
  input wire [15:0] reset_vector_o,
  input wire irq_pending_o,
  input wire [2:0] irq_vector_o,
  input wire stack_push_o,
  input wire [7:0] reg_rdata_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  reg [12:0] oe_q; // Cycles the pin has been driven
  reg [6:0] tl_q; // Tail cycles, pin free and high
  reg drove_q; // This reset drove the pin itself
  // The drive counter saturates so a long hold never wraps
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q <= 13'h0000;
      tl_q <= 7'h00;
      drove_q <= 1'b1;
    end else begin
      // External resets have no drive phase, so their tail is not timed
      drove_q <= reset_pin_oe_o | (drove_q & internal_reset_signal_o);
      oe_q <= reset_pin_oe_o ? oe_q + {12'h000, oe_q != 13'h1fff} : 13'h0000;
      tl_q <= (internal_reset_signal_o && !reset_pin_oe_o && reset_pin_n_i) ? tl_q + 7'h01 : 7'h00;
    end
  end
  chk_drive_len: assert property ($fell(reset_pin_oe_o) |->
    (oe_q >= 13'd31 && oe_q <= 13'd33) || oe_q >= 13'd4090) else $error("pin drive length wrong");
  chk_tail_len: assert property ($fell(internal_reset_signal_o) && drove_q |->
    (tl_q >= 7'd31 && tl_q <= 7'd35) || (tl_q >= 7'd63 && tl_q <= 7'd67)) else $error("tail length wrong");
  chk_opcode_resets: assert property (bad_opcode_i && cpu_clk_en_o |-> ##[1:3] reset_pin_oe_o)
    else $error("bad opcode gave no reset");
  chk_pin_halts: assert property (!reset_pin_n_i [*5] |-> internal_reset_signal_o)
    else $error("low pin did not halt");
  chk_clk_gated: assert property (internal_reset_signal_o |-> !cpu_clk_en_o)
    else $error("clock on during reset");
  chk_open_drain: assert property (reset_pin_oe_o |-> !reset_pin_o)
    else $error("pin driven high");
  chk_vector_fixed: assert property (reset_vector_o == 16'hfffe || reset_vector_o == 16'hfefe)
    else $error("bad reset vector");
  chk_irq_held: assert property ($past(irq_pending_o) && irq_pending_o |-> $stable(irq_vector_o))
    else $error("latched vector displaced");
  chk_reset_wins: assert property (internal_reset_signal_o |-> !stack_push_o)
    else $error("stacking during reset");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside slot");
  cover property ($fell(internal_reset_signal_o));
  cover property (!reset_pin_n_i && !reset_pin_oe_o);
  cover property (stack_push_o);
endmodule // rss_reset_seq_chk
bind rss_reset_seq rss_reset_seq_chk u_chk (.clk_sys_i, .rst_n_i, .bad_opcode_i, .reset_pin_n_i, .reg_rd_i,
  .cpu_clk_en_o, .reset_pin_oe_o, .reset_pin_o, .internal_reset_signal_o, .reset_vector_o, .irq_pending_o,
  .irq_vector_o, .stack_push_o, .reg_rdata_o);

//--- sim/rss_pin_partner.sv
`timescale 1ns/100ps
// ==========================================================
// External chip sharing the open-drain reset line
module rss_pin_partner (
  // Clock and command
  input wire clk_sys_i,
  input wire start_i,
  input wire [7:0] len_i,
  // Pull-down only, never drives high
  output reg pull_low_o = 1'b0
);
  reg [7:0] cnt_q = 8'h00; // Cycles left to hold
  // Hold the line low for exactly the commanded count
  always @(posedge clk_sys_i) begin
    if (start_i) begin
      cnt_q <= len_i;
      pull_low_o <= 1'b1;
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      cnt_q <= 8'h00;
      pull_low_o <= 1'b0;
    end
  end
endmodule // rss_pin_partner

//--- sim/tb_reset_sequencer_with_prescale_counter.sv
`timescale 1ns/100ps
`include "rss_defines.vh"
// ==========================================================
// Self-checking bench
module tb_reset_sequencer_with_prescale_counter;
  reg clk_sys_i = 1'b0, rst_n_i = 1'b0, power_on_pulse_i = 1'b0, low_voltage_i = 1'b0;
  reg wdog_overflow_i = 1'b0, bad_opcode_i = 1'b0, stop_exec_i = 1'b0, opcode_fetch_i = 1'b0;
  reg unmapped_addr_i = 1'b0, wake_event_i = 1'b0, irq_mask_i = 1'b0, irq_entry_i = 1'b0;
  reg irq_return_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, ext_go = 1'b0, rd_seen = 1'b0;
  reg [7:0] irq_req_i = 8'h00, reg_wdata_i = 8'h00, ext_len = 8'h00;
  reg [3:0] reg_addr_i = 4'h0;
  wire reset_pin_n_i, reset_pin_oe_o, reset_pin_o, internal_reset_signal_o, cpu_clk_en_o, pull_low;
  wire clock_generator_output_o, wdog_tick_o, irq_pending_o, stack_push_o, stack_pop_o;
  wire [15:0] reset_vector_o;
  wire [2:0] irq_vector_o;
  wire [7:0] reg_rdata_o;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  integer num_errors = 0, n_checks = 0, k, j;
  always #12.5 clk_sys_i = ~clk_sys_i;
  // Open-drain line: low when either party pulls
  assign reset_pin_n_i = (reset_pin_oe_o ? reset_pin_o : 1'b1) && !pull_low;
  rss_reset_seq u_dut (.clk_sys_i, .rst_n_i, .power_on_pulse_i, .low_voltage_i, .wdog_overflow_i,
    .bad_opcode_i, .stop_exec_i, .opcode_fetch_i, .unmapped_addr_i, .wake_event_i, .reset_pin_n_i,
    .reset_pin_oe_o, .reset_pin_o, .internal_reset_signal_o, .cpu_clk_en_o, .clock_generator_output_o,
    .reset_vector_o, .wdog_tick_o, .irq_req_i, .irq_mask_i, .irq_entry_i, .irq_return_i, .irq_pending_o,
    .irq_vector_o, .stack_push_o, .stack_pop_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  rss_pin_partner u_ext (.clk_sys_i, .start_i(ext_go), .len_i(ext_len), .pull_low_o(pull_low));
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp(input [15:0] e, input [15:0] g, input [63:0] nm);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_sys_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge clk_sys_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the read
  always @(posedge clk_sys_i) rd_seen <= reg_rd_i;
  always @(negedge clk_sys_i) if (rd_seen) cmp({8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_o}, "rdata");
  // Bounded wait for the run state
  task wait_run;
    repeat (3) @(posedge clk_sys_i);
    for (k = 0; k < 6000 && cpu_clk_en_o !== 1'b1; k++) @(posedge clk_sys_i);
    if (k >= 6000) cmp(16'h0001, 16'h0000, "run");
  endtask
  task fire(input [2:0] s);
    @(posedge clk_sys_i);
    case (s)
      3'd0: wdog_overflow_i <= 1'b1;
      3'd1: bad_opcode_i <= 1'b1;
      3'd2: stop_exec_i <= 1'b1;
      3'd3: {opcode_fetch_i, unmapped_addr_i} <= 2'b11;
      3'd4: unmapped_addr_i <= 1'b1;
      default: power_on_pulse_i <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    {wdog_overflow_i, bad_opcode_i, stop_exec_i, opcode_fetch_i, unmapped_addr_i, power_on_pulse_i} <= 6'h00;
    wait_run;
  endtask
  // Partner pulls the line for a random stretch
  task ext(input [7:0] n);
    @(posedge clk_sys_i);
    {ext_go, ext_len} <= {1'b1, n};
    @(posedge clk_sys_i);
    ext_go <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    wait_run;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    num_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'hd6ecf41a));
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    cmp(`RSS_VEC_NORMAL, reset_vector_o, "vector");
    wait_run;
    fire(3'd5);
    rd(`RSS_OFS_CAUSE, 8'h80);
    rd(`RSS_OFS_CAUSE, 8'h00);
    wr(`RSS_OFS_CAUSE, 8'($urandom));
    wr(4'h2, 8'($urandom));
    rd(4'h2, 8'h00);
    rd(`RSS_OFS_CAUSE, 8'h00);
    for (j = 0; j < 5; j++) begin
      fire(j[2:0]);
      rd(`RSS_OFS_CAUSE, j == 0 ? 8'h20 : j < 3 ? 8'h10 : j == 3 ? 8'h08 : 8'h00);
    end
    wr(`RSS_OFS_CONFIG, 8'h01);
    fire(3'd0);
    rd(`RSS_OFS_CAUSE, 8'h00);
    wr(`RSS_OFS_CONFIG, 8'h00);
    ext(8'd68 + 8'($urandom % 16));
    rd(`RSS_OFS_CAUSE, 8'h40);
    ext(8'd20 + 8'($urandom % 30));
    rd(`RSS_OFS_CAUSE, 8'h00);
    // Stop allowed, short wake, monitor vector
    wr(`RSS_OFS_CONFIG, 8'h26);
    @(posedge clk_sys_i);
    stop_exec_i <= 1'b1;
    @(posedge clk_sys_i);
    stop_exec_i <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    cmp(16'h0000, {15'h0000, clock_generator_output_o}, "cgen");
    @(posedge clk_sys_i);
    wake_event_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_event_i <= 1'b0;
    wait_run;
    cmp(`RSS_VEC_MONITOR, reset_vector_o, "vector");
    wr(`RSS_OFS_CONFIG, 8'h00);
    @(posedge clk_sys_i);
    irq_req_i <= 8'h0c;
    repeat (3) @(posedge clk_sys_i);
    irq_req_i <= 8'h0d;
    repeat (3) @(negedge clk_sys_i);
    cmp(16'h0002, {13'h0000, irq_vector_o}, "irqvec");
    @(posedge clk_sys_i);
    irq_entry_i <= 1'b1;
    @(posedge clk_sys_i);
    {irq_entry_i, irq_req_i} <= 9'h000;
    @(negedge clk_sys_i);
    cmp(16'h0001, {15'h0000, stack_push_o}, "push");
    print_verdict;
  end
endmodule // tb_reset_sequencer_with_prescale_counter
